// file: dpm_defines.svh
// Constants for the DiffServ priority map: register indices, byte addresses, field layout, reset values.
// Assumes APB with 32-bit data; each byte-wide register sits in the low byte of one aligned word.
// Summary of operation
// RULE_01: Each IP frame's priority is the 2-bit field picked by bits 7 to 2 of its TOS or traffic-class byte.
// RULE_02: Register 0x63 gives code 0x0C from bits 1-0, code 0x0D from bits 3-2 and code 0x0E from bits 5-4.
// RULE_03: Register 0x64 maps codes 0x10 to 0x13, lowest code in bits 1-0 up to the highest in bits 7-6.
// RULE_04: Register 0x65 maps codes 0x14 to 0x17 in ascending pairs from the least significant pair.
// RULE_05: Register 0x66 maps codes 0x18 to 0x1B in ascending pairs from the least significant pair.
// RULE_06: Register 0x67 maps codes 0x1C to 0x1F in ascending pairs from the least significant pair.
// RULE_07: Register 0x68 maps codes 0x20 to 0x23 in ascending pairs from the least significant pair.
// RULE_08: Register 0x69 maps codes 0x24 to 0x27 in ascending pairs from the least significant pair.
// RULE_09: Register 0x6A gives code 0x29 from bits 3-2, code 0x2A from bits 5-4 and code 0x2B from bits 7-6.
// RULE_10: Every priority field is software readable and writable and resets to binary 00.
// RULE_11: All 64 codes are fully decoded, each to a field of its own, 128 bits in all.
// RULE_12: The lookup takes one pipeline stage and uses the field contents current when the frame is classified.
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH

// Register indices; byte address is four times the index
`define DPM_IDX_CODES_00_03 10'h060
`define DPM_IDX_CODES_04_07 10'h061
`define DPM_IDX_CODES_08_0B 10'h062
`define DPM_IDX_CODES_0C_0F 10'h063
`define DPM_IDX_CODES_10_13 10'h064
`define DPM_IDX_CODES_14_17 10'h065
`define DPM_IDX_CODES_18_1B 10'h066
`define DPM_IDX_CODES_1C_1F 10'h067
`define DPM_IDX_CODES_20_23 10'h068
`define DPM_IDX_CODES_24_27 10'h069
`define DPM_IDX_CODES_28_2B 10'h06a
`define DPM_IDX_CODES_2C_2F 10'h06b
`define DPM_IDX_CODES_30_33 10'h06c
`define DPM_IDX_CODES_34_37 10'h06d
`define DPM_IDX_CODES_38_3B 10'h06e
`define DPM_IDX_CODES_3C_3F 10'h06f
`define DPM_IDX_FIRST `DPM_IDX_CODES_00_03
`define DPM_IDX_LAST `DPM_IDX_CODES_3C_3F
`define DPM_NUM_REGS 16
`define DPM_REG_W 8

// APB address layout
`define DPM_ADDR_W 12
`define DPM_ADDR_IDX_LSB 2
`define DPM_IDX_W 10

// Field layout
`define DPM_TOS_CODE_MSB 7
`define DPM_TOS_CODE_LSB 2
`define DPM_CODE_W 6
`define DPM_PRIO_W 2
`define DPM_FIELDS_PER_REG 4
`define DPM_NUM_CODES 64

// Reset values
`define DPM_REG_RST 8'h00
`define DPM_PRIO_RST 2'h0

`endif

// file: dpm_map.sv
// DiffServ priority map: 16 byte-wide registers of 2-bit priorities behind an APB slave,
// plus a one-stage lookup from a frame's TOS byte to its priority.
// Assumes the frame parser presents tos_valid only for IP frames, synchronous to pclk.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "dpm_defines.svh"

module dpm_map
  import dpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DPM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tos_valid,
  input wire logic [7:0] tos_byte,
  output logic prio_valid,
  output logic [`DPM_PRIO_W-1:0] prio,
  output logic [`DPM_CODE_W-1:0] prio_code
);

  dpm_apb_state_t state_q;
  dpm_apb_state_t state_d;
  dpm_reg_t map_q [`DPM_NUM_REGS];
  dpm_reg_t map_d [`DPM_NUM_REGS];
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic prio_valid_q;
  logic prio_valid_d;
  dpm_prio_t prio_q;
  dpm_prio_t prio_d;
  dpm_code_t prio_code_q;
  dpm_code_t prio_code_d;
  logic setup;
  logic access;
  logic wr_done;
  logic [3:0] acc_slot;
  logic acc_hit;
  logic [`DPM_NUM_REGS-1:0] wr_sel;
  dpm_reg_t rd_byte;
  dpm_code_t frm_code;
  logic [`DPM_NUM_CODES-1:0] code_hit;
  dpm_prio_t code_field [`DPM_NUM_CODES];
  dpm_prio_t frm_prio;
  // Whole map as one vector, two bits per code, code 0 in the lowest pair
  logic [`DPM_PRIO_W*`DPM_NUM_CODES-1:0] prio_set;

  // Named views of the sixteen map registers
  dpm_reg_t diffserv_prio_codes_00_03;
  dpm_reg_t diffserv_prio_codes_04_07;
  dpm_reg_t diffserv_prio_codes_08_0b;
  dpm_reg_t diffserv_prio_codes_0c_0f;
  dpm_reg_t diffserv_prio_codes_10_13;
  dpm_reg_t diffserv_prio_codes_14_17;
  dpm_reg_t diffserv_prio_codes_18_1b;
  dpm_reg_t diffserv_prio_codes_1c_1f;
  dpm_reg_t diffserv_prio_codes_20_23;
  dpm_reg_t diffserv_prio_codes_24_27;
  dpm_reg_t diffserv_prio_codes_28_2b;
  dpm_reg_t diffserv_prio_codes_2c_2f;
  dpm_reg_t diffserv_prio_codes_30_33;
  dpm_reg_t diffserv_prio_codes_34_37;
  dpm_reg_t diffserv_prio_codes_38_3b;
  dpm_reg_t diffserv_prio_codes_3c_3f;

  // Register slot of a byte address, and whether the address maps at all
  function automatic logic [3:0] slot_of(input logic [`DPM_ADDR_W-1:0] a);
    logic [`DPM_IDX_W-1:0] idx;
    idx = a[`DPM_ADDR_W-1:`DPM_ADDR_IDX_LSB];
    slot_of = idx[3:0];
  endfunction

  function automatic logic maps(input logic [`DPM_ADDR_W-1:0] a);
    logic [`DPM_IDX_W-1:0] idx;
    idx = a[`DPM_ADDR_W-1:`DPM_ADDR_IDX_LSB];
    maps = (a[1:0] == 2'h0) && (idx >= `DPM_IDX_FIRST) && (idx <= `DPM_IDX_LAST); // RULE_11
  endfunction

  assign setup = psel && !penable;
  assign acc_slot = slot_of(paddr);
  assign acc_hit = maps(paddr);
  assign access = (state_q == DPM_ST_ACCESS);
  // Write lands only at the completing access edge
  assign wr_done = psel && penable && pwrite && access && acc_hit && pstrb[0];

  assign diffserv_prio_codes_00_03 = map_q[0];
  assign diffserv_prio_codes_04_07 = map_q[1];
  assign diffserv_prio_codes_08_0b = map_q[2];
  assign diffserv_prio_codes_0c_0f = map_q[3];
  assign diffserv_prio_codes_10_13 = map_q[4];
  assign diffserv_prio_codes_14_17 = map_q[5];
  assign diffserv_prio_codes_18_1b = map_q[6];
  assign diffserv_prio_codes_1c_1f = map_q[7];
  assign diffserv_prio_codes_20_23 = map_q[8];
  assign diffserv_prio_codes_24_27 = map_q[9];
  assign diffserv_prio_codes_28_2b = map_q[10];
  assign diffserv_prio_codes_2c_2f = map_q[11];
  assign diffserv_prio_codes_30_33 = map_q[12];
  assign diffserv_prio_codes_34_37 = map_q[13];
  assign diffserv_prio_codes_38_3b = map_q[14];
  assign diffserv_prio_codes_3c_3f = map_q[15];

  // Read mux over the named registers; all sixteen slots exist, so no default
  always_comb begin
    rd_byte = `DPM_REG_RST;
    unique case (acc_slot)
      4'h0: begin
        rd_byte = diffserv_prio_codes_00_03;
      end
      4'h1: begin
        rd_byte = diffserv_prio_codes_04_07;
      end
      4'h2: begin
        rd_byte = diffserv_prio_codes_08_0b;
      end
      4'h3: begin
        rd_byte = diffserv_prio_codes_0c_0f;
      end
      4'h4: begin
        rd_byte = diffserv_prio_codes_10_13;
      end
      4'h5: begin
        rd_byte = diffserv_prio_codes_14_17;
      end
      4'h6: begin
        rd_byte = diffserv_prio_codes_18_1b;
      end
      4'h7: begin
        rd_byte = diffserv_prio_codes_1c_1f;
      end
      4'h8: begin
        rd_byte = diffserv_prio_codes_20_23;
      end
      4'h9: begin
        rd_byte = diffserv_prio_codes_24_27;
      end
      4'ha: begin
        rd_byte = diffserv_prio_codes_28_2b;
      end
      4'hb: begin
        rd_byte = diffserv_prio_codes_2c_2f;
      end
      4'hc: begin
        rd_byte = diffserv_prio_codes_30_33;
      end
      4'hd: begin
        rd_byte = diffserv_prio_codes_34_37;
      end
      4'he: begin
        rd_byte = diffserv_prio_codes_38_3b;
      end
      4'hf: begin
        rd_byte = diffserv_prio_codes_3c_3f;
      end
    endcase
  end

  // Byte order follows the register order, so code c sits at bits 2c+1:2c
  assign prio_set = {
    diffserv_prio_codes_3c_3f,
    diffserv_prio_codes_38_3b,
    diffserv_prio_codes_34_37,
    diffserv_prio_codes_30_33,
    diffserv_prio_codes_2c_2f,
    diffserv_prio_codes_28_2b,
    diffserv_prio_codes_24_27,
    diffserv_prio_codes_20_23,
    diffserv_prio_codes_1c_1f,
    diffserv_prio_codes_18_1b,
    diffserv_prio_codes_14_17,
    diffserv_prio_codes_10_13,
    diffserv_prio_codes_0c_0f,
    diffserv_prio_codes_08_0b,
    diffserv_prio_codes_04_07,
    diffserv_prio_codes_00_03
  };

  // APB phase tracking; every access completes with no wait state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DPM_ST_IDLE: begin
        if (setup) begin
          state_d = DPM_ST_ACCESS;
        end
      end
      DPM_ST_ACCESS: begin
        if (!setup) begin
          state_d = DPM_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DPM_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Answer prepared during setup so the outputs come straight from flops
  always_comb begin
    pready_d = setup;
    pslverr_d = setup && !acc_hit; // RULE_11
    // Reads see the byte in the low lane, upper bits zero
    prdata_d = 32'h0000_0000;
    if (setup && !pwrite && acc_hit) begin
      prdata_d = {24'h00_0000, rd_byte}; // RULE_10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // One byte-wide register per group of four codes; fields ascend from bit 0
  genvar g;
  generate
    for (g = 0; g < `DPM_NUM_REGS; g++) begin : gen_map
      assign wr_sel[g] = wr_done && (acc_slot == 4'(g));
      // A write with the low byte strobe clear leaves the register alone
      assign map_d[g] = wr_sel[g] ? pwdata[`DPM_REG_W-1:0] : map_q[g]; // RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          map_q[g] <= `DPM_REG_RST; // RULE_10
        end else begin
          map_q[g] <= map_d[g];
        end
      end
    end
  endgenerate

  assign frm_code = tos_byte[`DPM_TOS_CODE_MSB:`DPM_TOS_CODE_LSB]; // RULE_01

  // Fully decoded: each code has its own select line into the priority set
  genvar c;
  generate
    for (c = 0; c < `DPM_NUM_CODES; c++) begin : gen_code
      assign code_hit[c] = (frm_code == dpm_code_t'(c)); // RULE_11
      assign code_field[c] = prio_set[`DPM_PRIO_W*c +: `DPM_PRIO_W];
    end
  endgenerate

  // Only one select is ever high, so an OR of the gated fields is the lookup
  always_comb begin
    frm_prio = `DPM_PRIO_RST;
    for (int k = 0; k < `DPM_NUM_CODES; k++) begin
      if (code_hit[k]) begin
        frm_prio = frm_prio | code_field[k];
      end
    end
  end

  // Lookup reads the contents before any write in the same cycle, so a write affects later frames only
  always_comb begin
    prio_valid_d = tos_valid; // RULE_12
    prio_d = prio_q;
    prio_code_d = prio_code_q;
    if (tos_valid) begin
      prio_d = frm_prio; // RULE_01 RULE_11 RULE_12
      prio_code_d = frm_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_valid_q <= 1'b0;
    end else begin
      prio_valid_q <= prio_valid_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_q <= `DPM_PRIO_RST;
    end else begin
      prio_q <= prio_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_code_q <= '0;
    end else begin
      prio_code_q <= prio_code_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prio_valid = prio_valid_q;
  assign prio = prio_q;
  assign prio_code = prio_code_q;

endmodule

// file: dpm_map_chk.sv
// Checker for dpm_map: APB answer timing, error decode, lookup timing.
// Assumes one clock domain and the bind at the foot.
`timescale 1ns/10ps
module dpm_map_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tos_valid,
  input wire logic prio_valid,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [7:0] tos_byte,
  input wire logic [1:0] prio,
  input wire logic [5:0] prio_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic stp = psel && !penable;
  wire logic hit = paddr[11:6] == 6'h06 && paddr[1:0] == 2'h0;
  wire logic [5:0] code = tos_byte[7:2];
  AST_RDY: assert property (stp |=> pready) else $error("ready late");
  AST_IDLE: assert property (!stp |=> !pready) else $error("ready stray");
  AST_ERR: assert property (stp && !hit |=> pslverr) else $error("no error");
  AST_OK: assert property (stp && hit |=> !pslverr) else $error("bad error");
  AST_RDZ: assert property (!pready |-> prdata == 32'h0) else $error("data stray");
  AST_PV: assert property (tos_valid |=> prio_valid && prio_code == $past(code)) else $error("lookup");
  AST_NPV: assert property (!tos_valid |=> !prio_valid) else $error("valid stray");
  AST_HOLD: assert property (!tos_valid |=> $stable(prio) && $stable(prio_code)) else $error("hold");
  cover property (stp && !hit);
  cover property (tos_valid ##1 tos_valid);
  cover property (prio_valid && prio == 2'h3);
endmodule
bind dpm_map dpm_map_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .tos_valid(tos_valid), .prio_valid(prio_valid), .paddr(paddr), .prdata(prdata),
  .tos_byte(tos_byte), .prio(prio), .prio_code(prio_code));

// file: dpm_map_test.sv
// Bench for dpm_map: APB register access and DiffServ lookup.
// Assumes the checker binds itself.
`timescale 1ns/10ps
module dpm_map_test;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0, er;
  logic tos_valid, prio_valid, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic [7:0] b = 8'h0, tos_byte, m [16];
  logic [1:0] prio;
  logic [5:0] prio_code;
  int fail_count = 0, checks = 0, cyc = 0;
  always #25 pclk = ~pclk;
  dpm_parser_model fp (.pclk(pclk), .go(go), .b(b), .tos_valid(tos_valid), .tos_byte(tos_byte));
  dpm_map dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tos_valid(tos_valid),
    .tos_byte(tos_byte), .prio_valid(prio_valid), .prio(prio), .prio_code(prio_code));
  task chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task frame(input logic [5:0] c);
    @(posedge pclk);
    go <= 1'h1;
    b <= {c, 2'h1};
    @(posedge pclk);
    go <= 1'h0;
    do @(negedge pclk); while (prio_valid !== 1'h1);
    chk("prio", m[c[5:2]] >> {c[1:0], 1'h0} & 2'h3, prio);
    chk("code", c, prio_code);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      m[i] = 8'h0;
      apb(1'h0, 12'h180 + 12'(4 * i), 32'h0, 4'h0);
      chk("reset", 32'h0, rd);
      frame(6'(4 * i + 3));
    end
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      m[i] = {4'(i) ^ 4'h9, 4'(i) ^ 4'h6};
      apb(1'h1, 12'h180 + 12'(4 * i), {24'ha5a5a5, m[i]}, 4'hf);
      apb(1'h0, 12'h180 + 12'(4 * i), 32'h0, 4'h0);
      chk("readback", {24'h0, m[i]}, rd);
    end
    for (int c = 0; c < 64; c++) frame(6'(c));
    $display("test map done");
    apb(1'h1, 12'h184, 32'hff, 4'h0);
    apb(1'h0, 12'h184, 32'h0, 4'h0);
    chk("strobe", {24'h0, m[1]}, rd);
    apb(1'h1, 12'h181, 32'hff, 4'hf);
    chk("misaligned", 32'h1, {31'h0, er});
    apb(1'h1, 12'h980, 32'hff, 4'hf);
    chk("far", 32'h1, {31'h0, er});
    apb(1'h0, 12'h180, 32'h0, 4'h0);
    chk("untouched", {24'h0, m[0]}, rd);
    apb(1'h1, 12'h17c, 32'hff, 4'hf);
    chk("unmapped", 32'h1, {31'h0, er});
    m[0] = 8'h1b;
    apb(1'h1, 12'h180, 32'h1b, 4'h1);
    frame(6'h00);
    frame(6'h03);
    $display("test refuse done");
    print_verdict;
  end
endmodule

// file: dpm_parser_model.sv
// Frame parser model: one TOS byte per frame request.
// Assumes requests on go, synchronous to pclk.
`timescale 1ns/10ps
module dpm_parser_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] b,
  output logic tos_valid = 1'h0,
  output logic [7:0] tos_byte = 8'h00
);
  always @(posedge pclk) begin
    tos_valid <= go;
    // Scrambled between frames so a stale byte never passes
    tos_byte <= go ? b : ~tos_byte;
  end
endmodule

// file: dpm_pkg.sv
// Types shared by the DiffServ priority map.
// Assumes dpm_defines.svh for widths.
`include "dpm_defines.svh"

package dpm_pkg;

  typedef enum logic [1:0] {
    DPM_ST_IDLE = 2'b01,
    DPM_ST_ACCESS = 2'b10
  } dpm_apb_state_t;

  typedef logic [`DPM_CODE_W-1:0] dpm_code_t;
  typedef logic [`DPM_PRIO_W-1:0] dpm_prio_t;
  typedef logic [`DPM_REG_W-1:0] dpm_reg_t;

endpackage
